/* rtl/pss_pkg.sv */
// package for the power search sequencer: widths, interval counts, state codes
// assumes a single 20 MHz clock domain and timer ticks already synchronous
package pss_pkg;
  // ------------------------------------------------------------
  // code widths and scales
  // ------------------------------------------------------------
  localparam int          CODE_W         = 7;       // quantised frequency / level width
  localparam int          FREQ_FS_KHZ    = 320;     // full scale of the 7-bit frequency code
  localparam int          PW_W           = 8;       // pulse-width control code width
  localparam int          RATIO_W        = 7;       // input-to-supply ratio code width
  localparam int          MIN_PW_NS      = 150;     // floor of the first sweep step
  localparam int          PW_GAIN_MILLI  = 576;     // 0.576 in thousandths
  localparam int          CLK_MHZ        = 20;
  localparam int          CLK_PERIOD_NS  = 1000 / CLK_MHZ;
  // least time rounds up to whole clock cycles
  localparam int          MIN_PW_CYC     = (MIN_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // interval lengths in timer periods
  // ------------------------------------------------------------
  localparam int          INIT_WAIT_TICKS = 256;    // initial_wait_interval
  localparam int          SETTLE_TICKS    = 32;     // step_settle_interval
  localparam int          DELAY_TICKS     = 65000;  // intersearch_delay_interval
  localparam int          TICK_W          = 17;
  localparam logic [6:0]  CODE_ALL_ONES   = 7'h7f;
  // ------------------------------------------------------------
  // sequencer states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    PSS_RESET  = 5'h01,
    PSS_WAIT   = 5'h02,
    PSS_SETTLE = 5'h04,
    PSS_HOLD   = 5'h08,
    PSS_DELAY  = 5'h10
  } pss_state_e;
endpackage

/* rtl/pss_tick_count.sv */
// tick counter used for every sequencer interval
// assumes tick is a one-cycle synchronous pulse of the selected timer clock
`timescale 1ns/100ps
module pss_tick_count #(
  parameter int W = 17
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [W-1:0] target,
  output logic              done
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // ------------------------------------------------------------
  // counter; clear wins so a restart never counts a stale tick
  // ------------------------------------------------------------
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (tick && !done) begin
      next_count = count + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
    end else if (ce) begin
      count <= next_count;
    end
  end

  assign done = (count == target);
endmodule

/* rtl/pss_sequencer.sv */
// power search sequencer: interval timing, pulse-width sweep, protection exits
// assumes ticks, codes and fault inputs are synchronous to clk
`timescale 1ns/100ps
// Behaviour
// (R1) frequency quantised to 7-bit code, 320 kHz
// (R2) limit is threshold ratio times full scale
// (R3) over-limit frequency stops power, releases status
// (R4) ramp end without exit faults until next search
// (R5) wait 256 step ticks before first step
// (R6) settle 32 step ticks after each step
// (R7) delay 65000 delay ticks between searches
// (R8) grounded minimum input gives 150 ns first step
// (R9) first step scales with minimum input ratio
// (R10) without receiver, only search pulses deliver power
// (R11) current limit after exit cuts power until next
// (R12) raise code one step per settle interval
// (R13) frequency fault holds bridge off, resumes after delay
module pss_sequencer #(
  parameter int PW_W        = pss_pkg::PW_W,
  parameter int DELAY_TICKS = pss_pkg::DELAY_TICKS
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        ce,
  input  wire logic                        step_tick,
  input  wire logic                        delay_tick,
  input  wire logic [pss_pkg::CODE_W-1:0]  drive_freq_code,
  input  wire logic [pss_pkg::RATIO_W-1:0] frequency_limit_input,
  input  wire logic [pss_pkg::RATIO_W-1:0] minimum_pulse_width_input,
  input  wire logic [PW_W-1:0]             min_code_span,
  input  wire logic                        exit_found,
  input  wire logic                        current_limit,
  output logic [PW_W-1:0]                  pulse_width_control_one,
  output logic [PW_W-1:0]                  pulse_width_control_two,
  output logic                             bridge_enable,
  output logic                             status_drive,
  output logic                             status_oe,
  output logic                             ramp_fault,
  output logic                             freq_fault,
  output logic [pss_pkg::CODE_W-1:0]       frequency_limit_code
);
  localparam logic [pss_pkg::TICK_W-1:0] WAIT_T   = pss_pkg::TICK_W'(pss_pkg::INIT_WAIT_TICKS);
  localparam logic [pss_pkg::TICK_W-1:0] SETTLE_T = pss_pkg::TICK_W'(pss_pkg::SETTLE_TICKS);
  localparam logic [pss_pkg::TICK_W-1:0] DELAY_T  = pss_pkg::TICK_W'(DELAY_TICKS);
  localparam logic [PW_W-1:0]            PW_MAX   = {PW_W{1'b1}};

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // first code of the sweep: zero span term gives the 150 ns floor
  function automatic logic [PW_W-1:0] first_code(input logic [pss_pkg::RATIO_W-1:0] ratio,
                                                 input logic [PW_W-1:0] span);
    logic [PW_W+pss_pkg::RATIO_W-1:0] prod;
    prod = span * ratio;
    first_code = prod[PW_W+pss_pkg::RATIO_W-1:pss_pkg::RATIO_W];
  endfunction

  function automatic logic freq_over(input logic [pss_pkg::CODE_W-1:0] f,
                                     input logic [pss_pkg::CODE_W-1:0] lim);
    freq_over = (f > lim);
  endfunction

  pss_pkg::pss_state_e  state;
  pss_pkg::pss_state_e  next_state;
  logic [PW_W-1:0]      pw;
  logic [PW_W-1:0]      next_pw;
  logic                 exited;
  logic                 next_exited;
  logic                 next_ramp_fault;
  logic                 next_freq_fault;
  logic                 power_off;
  logic                 next_power_off;
  logic [pss_pkg::CODE_W-1:0] next_lim;
  logic                 cnt_clear;
  logic                 cnt_tick;
  logic [pss_pkg::TICK_W-1:0] cnt_target;
  logic                 cnt_done;
  logic                 over;
  logic                 limit_programmed;

  // ------------------------------------------------------------
  // shared interval counter
  // ------------------------------------------------------------
  // one counter serves all three intervals; they never overlap
  pss_tick_count #(
    .W (pss_pkg::TICK_W)
  ) u_count (
    .clk    (clk),
    .sys_rst(sys_rst),
    .ce     (ce),
    .clear  (cnt_clear),
    .tick   (cnt_tick),
    .target (cnt_target),
    .done   (cnt_done)
  );

  always_comb begin
    cnt_tick   = step_tick;
    cnt_target = SETTLE_T;
    case (state)
      pss_pkg::PSS_WAIT:   cnt_target = WAIT_T;        // R5
      pss_pkg::PSS_SETTLE: cnt_target = SETTLE_T;      // R6
      pss_pkg::PSS_DELAY: begin
        cnt_target = DELAY_T;                          // R7
        cnt_tick   = delay_tick;
      end
      default:             cnt_target = SETTLE_T;
    endcase
  end

  // ------------------------------------------------------------
  // frequency limit compare
  // ------------------------------------------------------------
  // the ratio code is already a 7-bit fraction of the 320 kHz scale
  assign limit_programmed = (frequency_limit_input != pss_pkg::CODE_ALL_ONES);
  assign over = limit_programmed && freq_over(drive_freq_code, frequency_limit_code); // R1 R3
  assign next_lim = frequency_limit_input;                                           // R2

  // ------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_pw         = pw;
    next_exited     = exited;
    next_ramp_fault = ramp_fault;
    next_freq_fault = freq_fault;
    next_power_off  = power_off;
    cnt_clear       = 1'b0;
    case (state)
      pss_pkg::PSS_RESET: begin
        next_pw         = '0;
        next_exited     = 1'b0;
        next_ramp_fault = 1'b0;
        next_freq_fault = 1'b0;
        next_power_off  = 1'b0;
        cnt_clear       = 1'b1;
        next_state      = pss_pkg::PSS_WAIT;
      end
      pss_pkg::PSS_WAIT: begin
        if (cnt_done) begin
          next_pw    = first_code(minimum_pulse_width_input, min_code_span); // R8 R9
          cnt_clear  = 1'b1;
          next_state = pss_pkg::PSS_SETTLE;
        end
      end
      pss_pkg::PSS_SETTLE: begin
        if (over) begin
          next_freq_fault = 1'b1;                      // R3 R13
          next_power_off  = 1'b1;
          cnt_clear       = 1'b1;
          next_state      = pss_pkg::PSS_DELAY;
        end else if (cnt_done) begin
          cnt_clear = 1'b1;
          if (exit_found) begin
            next_exited = 1'b1;
            next_state  = pss_pkg::PSS_HOLD;
          end else if (pw == PW_MAX) begin
            next_ramp_fault = 1'b1;                    // R4 R10
            next_power_off  = 1'b1;
            next_state      = pss_pkg::PSS_DELAY;
          end else begin
            next_pw = pw + PW_W'(1);                   // R12
          end
        end
      end
      pss_pkg::PSS_HOLD: begin
        // power found; hold level until a frequency fault or the current limit after an exit
        if (over) begin
          next_freq_fault = 1'b1;                      // R3
          next_power_off  = 1'b1;
          cnt_clear       = 1'b1;
          next_state      = pss_pkg::PSS_DELAY;
        end else if (current_limit && exited) begin
          next_power_off = 1'b1;                       // R11
          cnt_clear      = 1'b1;
          next_state     = pss_pkg::PSS_DELAY;
        end
      end
      pss_pkg::PSS_DELAY: begin
        // every entry here sets power_off, so the bridge stays off through the delay
        if (cnt_done) begin
          next_state = pss_pkg::PSS_RESET;             // R7 R13
        end
      end
      default: begin
        next_state = pss_pkg::PSS_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state                <= pss_pkg::PSS_RESET;
      pw                   <= '0;
      exited               <= 1'b0;
      ramp_fault           <= 1'b0;
      freq_fault           <= 1'b0;
      power_off            <= 1'b0;
      frequency_limit_code <= '0;
    end else if (ce) begin
      state                <= next_state;
      pw                   <= next_pw;
      exited               <= next_exited;
      ramp_fault           <= next_ramp_fault;
      freq_fault           <= next_freq_fault;
      power_off            <= next_power_off;
      frequency_limit_code <= next_lim;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign pulse_width_control_one = pw;
  assign pulse_width_control_two = pw;
  // bridge off during reset and wait; on while stepping or holding
  assign bridge_enable = !power_off && (state == pss_pkg::PSS_SETTLE || state == pss_pkg::PSS_HOLD ||
                                        state == pss_pkg::PSS_DELAY);    // R10 R13
  // status is open-drain: pulled low while powering, released on freq fault
  assign status_drive = 1'b0;
  assign status_oe    = !freq_fault;                                    // R3

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // interval monitor kept apart from the shared counter, so a wrong
  // target or a tick lost at a restart shows up as a length mismatch
  logic [pss_pkg::TICK_W-1:0] mon_ticks;
  logic [pss_pkg::TICK_W-1:0] next_mon_ticks;
  logic                       mon_tick;

  always_comb begin
    mon_tick       = (state == pss_pkg::PSS_DELAY) ? delay_tick : step_tick;
    next_mon_ticks = mon_ticks;
    if (next_state != state || next_pw != pw) begin
      next_mon_ticks = '0;
    end else if (mon_tick && mon_ticks != '1) begin
      next_mon_ticks = mon_ticks + pss_pkg::TICK_W'(1);
    end
  end

  // same enable as the sequencer, so a frozen interval stays frozen here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mon_ticks <= '0;
    end else if (ce) begin
      mon_ticks <= next_mon_ticks;
    end
  end

  // exits and faults
  a_freq_stop: assert property (@(posedge clk) disable iff (sys_rst) // R3
    ce && over && state == pss_pkg::PSS_SETTLE |=> !bridge_enable && !status_oe)
    else $error("frequency over limit did not stop power");
  a_ramp_end: assert property (@(posedge clk) disable iff (sys_rst) // R4
    ce && state == pss_pkg::PSS_SETTLE && cnt_done && !over && !exit_found && pw == PW_MAX
    |=> ramp_fault && !bridge_enable)
    else $error("ramp end did not fault");
  a_step_inc: assert property (@(posedge clk) disable iff (sys_rst) // R12
    ce && state == pss_pkg::PSS_SETTLE && cnt_done && !over && !exit_found && pw != PW_MAX
    |=> pw == $past(pw) + PW_W'(1))
    else $error("pulse width did not step by one");
  a_first_step: assert property (@(posedge clk) disable iff (sys_rst) // R8
    ce && state == pss_pkg::PSS_WAIT && cnt_done && minimum_pulse_width_input == '0
    |=> pw == '0)
    else $error("first step not at floor");
  a_ilim_cut: assert property (@(posedge clk) disable iff (sys_rst) // R11
    ce && state == pss_pkg::PSS_HOLD && !over && current_limit && exited |=> !bridge_enable)
    else $error("current limit did not cut power");
  a_off_held: assert property (@(posedge clk) disable iff (sys_rst) // R13
    power_off && state == pss_pkg::PSS_DELAY |=> !bridge_enable)
    else $error("bridge restarted before delay end");
  // the reset-release edge is excluded: the register still holds its reset value there
  a_limit_load: assert property (@(posedge clk) disable iff (sys_rst) // R2
    ce && !sys_rst |=> frequency_limit_code == $past(frequency_limit_input))
    else $error("limit code not loaded");

  // interval lengths, judged by the monitor
  a_wait_len: assert property (@(posedge clk) disable iff (sys_rst) // R5
    ce && state != pss_pkg::PSS_SETTLE && next_state == pss_pkg::PSS_SETTLE
    |-> state == pss_pkg::PSS_WAIT && mon_ticks == WAIT_T)
    else $error("stepping entered without the full initial wait");
  a_settle_len: assert property (@(posedge clk) disable iff (sys_rst) // R6
    ce && state == pss_pkg::PSS_SETTLE && cnt_done && !over |-> mon_ticks == SETTLE_T)
    else $error("settle interval did not last its tick count");
  a_delay_len: assert property (@(posedge clk) disable iff (sys_rst) // R7
    ce && state == pss_pkg::PSS_DELAY && cnt_done |-> mon_ticks == DELAY_T)
    else $error("delay interval did not last its tick count");

  // restart and sticky status
  a_reset_clean: assert property (@(posedge clk) disable iff (sys_rst) // R13
    ce && !sys_rst && state == pss_pkg::PSS_RESET |=> !ramp_fault && !freq_fault && pw == '0)
    else $error("new search did not start clean");
  a_status_hold: assert property (@(posedge clk) disable iff (sys_rst) // R3
    ce && !sys_rst && freq_fault && state != pss_pkg::PSS_RESET |=> freq_fault && !status_oe)
    else $error("status release lost before restart");

  // main scenarios
  c_ramp_fault: cover property (@(posedge clk) $rose(ramp_fault));
  c_freq_fault: cover property (@(posedge clk) $rose(freq_fault));
  c_exit_hold:  cover property (@(posedge clk) state == pss_pkg::PSS_HOLD);
  c_restart:    cover property (@(posedge clk) state == pss_pkg::PSS_DELAY ##1 state == pss_pkg::PSS_RESET);
  c_ilim_cut:   cover property (@(posedge clk) state == pss_pkg::PSS_HOLD ##1 state == pss_pkg::PSS_DELAY);
endmodule

/* bench/pss_tank_model.sv */
// behavioural model of the series lc transmit tank and coil seen by the sequencer
// assumes one clk domain; the tank only rings while the bridge is enabled
`timescale 1ns/100ps
module pss_tank_model (
  input  wire logic       clk,
  input  wire logic       bridge_enable,
  input  wire logic [7:0] pulse_width,
  input  wire logic [6:0] res_code,
  input  wire logic       foreign_object,
  input  wire logic       receiver,
  input  wire logic [7:0] exit_level,
  output logic      [6:0] drive_freq_code,
  output logic            exit_found
);
  // ------------------------------------------------------------
  // resonant frequency seen by the converter, one cycle of lag
  // ------------------------------------------------------------
  // a metal object lowers coil inductance, so the tank rings higher
  always_ff @(posedge clk) begin
    if (!bridge_enable) begin
      drive_freq_code <= 7'h00;
    end else if (foreign_object) begin
      drive_freq_code <= res_code + 7'h14;
    end else begin
      drive_freq_code <= res_code;
    end
  end

  // a receiver only answers once the pulse width is high enough
  assign exit_found = receiver & bridge_enable & (pulse_width >= exit_level);
endmodule

/* bench/power_search_sequencer_tb.sv */
// self-checking bench for the power search sequencer
// assumes the sequencer and its tank model; timer ticks come every other clk
`timescale 1ns/100ps
module power_search_sequencer_tb;
  localparam int DLY = 40;
  logic       clk, sys_rst, ce, tick_on, exit_found, current_limit;
  logic       step_tick = 1'b0;
  logic       delay_tick = 1'b0;
  logic       foreign, receiver, bridge_enable, status_drive, status_oe, ramp_fault, freq_fault;
  logic [6:0] drive_freq_code, frequency_limit_input, minimum_pulse_width_input, res_code, lim_code;
  logic [7:0] min_code_span, pw1, pw2, exit_level;
  int         n_mismatch, tests_run;
  int         n_step = 0;
  int         n_dly = 0;

  // ------------------------------------------------------------
  // clock, timer ticks, design and tank
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ticks stop during reset so every interval count starts clean
  always @(posedge clk) begin
    step_tick <= tick_on & ~step_tick;
    delay_tick <= tick_on & ~delay_tick;
    if (step_tick) n_step <= n_step + 1;
    if (delay_tick) n_dly <= n_dly + 1;
  end
  pss_sequencer #(.DELAY_TICKS(DLY)) i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .step_tick(step_tick),
    .delay_tick(delay_tick), .drive_freq_code(drive_freq_code), .frequency_limit_input(frequency_limit_input),
    .minimum_pulse_width_input(minimum_pulse_width_input), .min_code_span(min_code_span),
    .exit_found(exit_found), .current_limit(current_limit), .pulse_width_control_one(pw1),
    .pulse_width_control_two(pw2), .bridge_enable(bridge_enable), .status_drive(status_drive),
    .status_oe(status_oe), .ramp_fault(ramp_fault), .freq_fault(freq_fault), .frequency_limit_code(lim_code));
  pss_tank_model i_tank (.clk(clk), .bridge_enable(bridge_enable), .pulse_width(pw1), .res_code(res_code),
    .foreign_object(foreign), .receiver(receiver), .exit_level(exit_level),
    .drive_freq_code(drive_freq_code), .exit_found(exit_found));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic [6:0] lim, input logic [6:0] ratio, input logic [7:0] span);
    @(posedge clk);
    sys_rst <= 1'b1;
    tick_on <= 1'b0;
    current_limit <= 1'b0;
    foreign <= 1'b0;
    frequency_limit_input <= lim;
    minimum_pulse_width_input <= ratio;
    min_code_span <= span;
    cyc(1);
    check(bridge_enable, 1'b0);
    check(status_oe, 1'b1);
    @(posedge clk);
    sys_rst <= 1'b0;
    cyc(2);
    @(posedge clk);
    tick_on <= 1'b1;
    #1;
  endtask
  // waits out the initial interval and checks the first sweep code
  task automatic reach_settle(input logic [7:0] exp_code);
    int s;
    s = n_step;
    for (int i = 0; i < 2000 && bridge_enable !== 1'b1; i++) cyc(1);
    check(n_step - s, 256);
    check(pw1, exp_code);
    check(pw2, exp_code);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_first_step;
    do_reset(7'h7f, 7'h00, 8'hc8);
    reach_settle(8'h00);
    do_reset(7'h7f, 7'h40, 8'h64);
    reach_settle(8'h32);
  endtask
  // sweep from near the top of the ramp with nobody answering
  task automatic t_ramp_end;
    int s;
    do_reset(7'h7f, 7'h7f, 8'hff);
    reach_settle(8'hfd);
    s = n_step;
    for (int i = 0; i < 200 && pw1 === 8'hfd; i++) cyc(1);
    check(pw1, 8'hfe);
    check(n_step - s, 32);
    for (int i = 0; i < 200 && ramp_fault !== 1'b1; i++) cyc(1);
    check(bridge_enable, 1'b0);
    check(freq_fault, 1'b0);
    s = n_dly;
    for (int i = 0; i < 300 && ramp_fault !== 1'b0; i++) cyc(1);
    check((n_dly - s >= DLY) && (n_dly - s <= DLY + 1), 1'b1);
    check(bridge_enable, 1'b0);
  endtask
  // a frequency equal to the limit is allowed, a metal object above it trips
  task automatic t_freq_limit;
    do_reset(7'h28, 7'h00, 8'h10);
    reach_settle(8'h00);
    cyc(40);
    check(lim_code, 7'h28);
    check(freq_fault, 1'b0);
    @(posedge clk);
    foreign <= 1'b1;
    cyc(1);
    for (int i = 0; i < 10 && freq_fault !== 1'b1; i++) cyc(1);
    check(freq_fault, 1'b1);
    check(status_oe, 1'b0);
    check(status_drive, 1'b0);
    check(bridge_enable, 1'b0);
    @(posedge clk);
    foreign <= 1'b0;
    cyc(50);
    check(bridge_enable, 1'b0);
    for (int i = 0; i < 300 && freq_fault !== 1'b0; i++) cyc(1);
    check(status_oe, 1'b1);
    for (int i = 0; i < 1000 && bridge_enable !== 1'b1; i++) cyc(1);
    check(pw1, 8'h00);
  endtask
  // clock enable low freezes the settle count: the step lands late, not lost
  task automatic t_clock_enable;
    do_reset(7'h7f, 7'h00, 8'h10);
    reach_settle(8'h00);
    @(posedge clk);
    ce <= 1'b0;
    cyc(100);
    check(pw1, 8'h00);
    check(bridge_enable, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    cyc(61);
    check(pw1, 8'h00);
    cyc(1);
    check(pw1, 8'h01);
  endtask
  // current limit is ignored while sweeping, obeyed after an exit
  task automatic t_current_limit;
    do_reset(7'h7f, 7'h00, 8'h10);
    reach_settle(8'h00);
    @(posedge clk);
    current_limit <= 1'b1;
    cyc(10);
    check(bridge_enable, 1'b1);
    @(posedge clk);
    current_limit <= 1'b0;
    cyc(200);
    check(pw1, 8'h01);
    check(bridge_enable, 1'b1);
    @(posedge clk);
    current_limit <= 1'b1;
    cyc(3);
    check(bridge_enable, 1'b0);
    cyc(50);
    check(bridge_enable, 1'b0);
  endtask

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // a hang costs at most about seven times the expected run
  initial begin
    #(50 * 30000);
    n_mismatch++;
    stop_test();
  end
  initial begin
    {sys_rst, ce, tick_on} = 3'b110;
    {current_limit, foreign, receiver} = 3'b000;
    n_mismatch = 0;
    tests_run = 0;
    res_code = 7'h28;
    exit_level = 8'hff;
    frequency_limit_input = 7'h7f;
    minimum_pulse_width_input = 7'h00;
    min_code_span = 8'h00;
    t_first_step();
    t_ramp_end();
    t_freq_limit();
    t_clock_enable();
    @(posedge clk);
    receiver <= 1'b1;
    exit_level <= 8'h01;
    t_current_limit();
    stop_test();
  end
endmodule
